// ### nhp_pkg.sv
package nhp_pkg;
  // Address and data widths of the device window
  localparam int ADDR_WIDTH = 13;
  localparam int DATA_WIDTH = 16;
  localparam int MUX_ADDR_BITS = 12;
  // Timing, in core_clk cycles at 20 MHz (50 ns)
  localparam int CLK_PERIOD_NS = 50;
  localparam int SETUP_NS = 50;
  localparam int STROBE_NS = 100;
  localparam int HOLD_NS = 50;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_WIDTH = 4;

  typedef struct packed {
    logic write;
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] wdata;
  } nhp_req_type;

  typedef struct packed {
    logic chip_sel_n;
    logic write_n;
    logic out_en_n;
    logic address_valid_n;
  } nhp_strobe_type;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_MODE = 6'h02,
    ST_ADDR = 6'h04,
    ST_SETUP = 6'h08,
    ST_STROBE = 6'h10,
    ST_HOLD = 6'h20
  } nhp_state_type;
endpackage

// ### nhp_host.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Write: chip select and write strobe both held low.
// - Read: chip select and output strobe held low; device drives data.
// - Burst clock is only for burst reads; this host never drives one.
// - Multiplexed: address-valid strobe on id bit 1, shared bus on data.
// - Address-valid phase carries address bits 12..1 on bus lines 11..0.
// - Mode edge comes after reset release and before any cycle.
// - Busy low while initialising; no access until released.
module nhp_host
  import nhp_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic mux_mode,
  input wire logic req_valid,
  output logic req_ready,
  input wire nhp_req_type req,
  output logic rsp_valid,
  output logic [DATA_WIDTH-1:0] rsp_data,
  output logic dev_reset_n,
  output logic [ADDR_WIDTH-1:0] dev_addr,
  output nhp_strobe_type dev_strobe,
  output logic [DATA_WIDTH-1:0] dev_data_out,
  output logic dev_data_oe,
  input wire logic [DATA_WIDTH-1:0] dev_data_in,
  input wire logic dev_busy_n,
  input wire logic dev_irq_n,
  input wire logic dev_dma_request_n,
  output logic irq_pending,
  output logic dma_pending
);
  // ****************************************
  // Reset and input synchronisers
  // ****************************************
  logic [1:0] rst_sync;
  logic rst_n;
  logic [2:0] in_meta;
  logic [2:0] in_sync;
  logic busy_free;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Busy held, irq and dma at idle high: no false request after reset
      in_meta <= 3'h3;
      in_sync <= 3'h3;
    end else begin
      in_meta <= {dev_busy_n, dev_irq_n, dev_dma_request_n};
      in_sync <= in_meta;
    end
  end
  assign busy_free = in_sync[2];
  // Open-drain flags, low means asserted
  assign irq_pending = ~in_sync[1];
  assign dma_pending = ~in_sync[0];
  assign dev_reset_n = rst_n;

  // ****************************************
  // Cycle sequencer
  // ****************************************
  nhp_state_type state, next_state;
  logic [CNT_WIDTH-1:0] cnt, next_cnt;
  logic mode_done, next_mode_done;
  nhp_req_type cur, next_cur;
  nhp_strobe_type next_strobe;
  logic [ADDR_WIDTH-1:0] next_addr;
  logic [DATA_WIDTH-1:0] next_dout;
  logic next_oe;
  logic [DATA_WIDTH-1:0] next_rdata;
  logic next_rsp_valid;

  assign req_ready = (state == ST_IDLE) && mode_done && busy_free;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_mode_done = mode_done;
    next_cur = cur;
    next_strobe = dev_strobe;
    next_addr = dev_addr;
    next_dout = dev_data_out;
    next_oe = dev_data_oe;
    next_rdata = rsp_data;
    next_rsp_valid = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (!mode_done && busy_free) begin
          // Mode strobe pulse only after reset release, before any cycle
          if (mux_mode) begin
            next_strobe.address_valid_n = 1'b0;
            next_cnt = CNT_WIDTH'(STROBE_CYC);
            next_state = ST_MODE;
          end else begin
            next_mode_done = 1'b1;
          end
        end else if (req_valid && req_ready) begin
          next_cur = req;
          next_strobe.chip_sel_n = 1'b0;
          if (mux_mode) begin
            // Address bits 12..1 on lines 11..0, upper lines zero
            next_dout = {4'h0, req.addr[ADDR_WIDTH-1:1]};
            next_oe = 1'b1;
            next_strobe.address_valid_n = 1'b0;
            next_cnt = CNT_WIDTH'(STROBE_CYC);
            next_state = ST_ADDR;
          end else begin
            // Plain strobed cycle, so no burst clock is ever offered
            next_addr = req.addr;
            next_dout = req.wdata;
            next_oe = req.write;
            next_cnt = CNT_WIDTH'(SETUP_CYC);
            next_state = ST_SETUP;
          end
        end
      end
      ST_MODE: begin
        if (cnt == 1) begin
          next_strobe.address_valid_n = 1'b1;
          next_mode_done = 1'b1;
          next_state = ST_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      ST_ADDR: begin
        if (cnt == 1) begin
          // Address-valid released; the device latched the address 10 ns after it fell
          next_strobe.address_valid_n = 1'b1;
          next_oe = cur.write;
          next_dout = cur.wdata;
          next_cnt = CNT_WIDTH'(SETUP_CYC);
          next_state = ST_SETUP;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      ST_SETUP: begin
        if (cnt == 1) begin
          next_strobe.write_n = ~cur.write;
          next_strobe.out_en_n = cur.write;
          next_cnt = CNT_WIDTH'(STROBE_CYC);
          next_state = ST_STROBE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      ST_STROBE: begin
        if (cnt == 1) begin
          next_strobe.write_n = 1'b1;
          next_strobe.out_en_n = 1'b1;
          if (!cur.write) begin
            next_rdata = dev_data_in;
            next_rsp_valid = 1'b1;
          end
          next_cnt = CNT_WIDTH'(HOLD_CYC);
          next_state = ST_HOLD;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      ST_HOLD: begin
        if (cnt == 1) begin
          next_strobe.chip_sel_n = 1'b1;
          next_oe = 1'b0;
          next_rsp_valid = cur.write;
          next_state = ST_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cnt <= '0;
      mode_done <= 1'b0;
      cur <= '0;
      dev_strobe <= '1;
      dev_addr <= '0;
      dev_data_out <= '0;
      dev_data_oe <= 1'b0;
      rsp_data <= '0;
      rsp_valid <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      mode_done <= next_mode_done;
      cur <= next_cur;
      dev_strobe <= next_strobe;
      dev_addr <= next_addr;
      dev_data_out <= next_dout;
      dev_data_oe <= next_oe;
      rsp_data <= next_rdata;
      rsp_valid <= next_rsp_valid;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_write_strobe_pair: assert property (@(posedge core_clk) disable iff (!rst_n)
    !dev_strobe.write_n |-> !dev_strobe.chip_sel_n && dev_data_oe)
    else $error("write strobe without chip select or data drive");
  a_read_strobe_pair: assert property (@(posedge core_clk) disable iff (!rst_n)
    !dev_strobe.out_en_n |-> !dev_strobe.chip_sel_n && !dev_data_oe)
    else $error("read strobe with bus driven");
  a_no_access_busy: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(dev_strobe.chip_sel_n) |-> $past(busy_free))
    else $error("access started while busy");
  a_mode_first: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(dev_strobe.chip_sel_n) && mux_mode |-> $past(mode_done))
    else $error("cycle before mode edge");
  a_addr_layout: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == ST_ADDR) |-> dev_data_out[DATA_WIDTH-1:MUX_ADDR_BITS] == 4'h0
      && dev_data_out[MUX_ADDR_BITS-1:0] == cur.addr[ADDR_WIDTH-1:1])
    else $error("multiplexed address misplaced");
  // Strobe pin itself must be low for both counted cycles, not just the state
  a_strobe_len: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(state == ST_STROBE) |->
      (state == ST_STROBE && !(dev_strobe.out_en_n && dev_strobe.write_n)) [*2]
      ##1 (dev_strobe.out_en_n && dev_strobe.write_n))
    else $error("strobe length wrong");
  // Looked at as the read strobe ends, when the captured word is shown
  a_rsp_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(dev_strobe.out_en_n) |-> rsp_valid && rsp_data == $past(dev_data_in))
    else $error("read data not returned");
  a_addr_valid_end: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(state == ST_ADDR) |-> ##[1:3] dev_strobe.address_valid_n)
    else $error("address-valid never released");
endmodule
`default_nettype wire

// ### nhp_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************
// Device model
// ****************
module nhp_dev_model
  import nhp_pkg::*;
#(
  parameter int BUSY_NS = 600
)
(
  input wire logic dev_reset_n,
  input wire logic [ADDR_WIDTH-1:0] dev_addr,
  input wire nhp_strobe_type strobe,
  input wire logic [DATA_WIDTH-1:0] host_data,
  input wire logic host_oe,
  input wire logic irq_cmd,
  input wire logic dma_cmd,
  output logic [DATA_WIDTH-1:0] bus,
  output logic busy_n,
  output logic irq_n,
  output logic dma_request_n
);
  logic [DATA_WIDTH-1:0] mem [0:4095];
  logic [DATA_WIDTH-1:0] last = '0;
  logic [MUX_ADDR_BITS-1:0] mux_addr = '0;
  logic [MUX_ADDR_BITS-1:0] word;
  logic mux_on = 1'b0;
  logic rd;
  initial busy_n = 1'b0;
  assign irq_n = !irq_cmd;
  assign dma_request_n = !dma_cmd;
  assign word = mux_on ? mux_addr : dev_addr[ADDR_WIDTH-1:1];
  assign rd = busy_n && !strobe.chip_sel_n && !strobe.out_en_n;
  // No pull-ups in 16-bit mode, so a released bus shows the inverse
  assign bus = host_oe ? host_data : (rd ? mem[word] : ~last);
  always @(bus) if (host_oe || rd) last = bus;
  always @(dev_reset_n) begin
    busy_n = 1'b0;
    mux_on = 1'b0;
    if (dev_reset_n === 1'b1) #(BUSY_NS) busy_n = 1'b1;
  end
  // Bus held two cycles, so sample inside the phase to dodge edge races
  always @(negedge strobe.address_valid_n) begin
    mux_on = 1'b1;
    #10;
    if (!strobe.chip_sel_n) mux_addr = bus[MUX_ADDR_BITS-1:0];
  end
  always @(posedge strobe.write_n) if (busy_n && !strobe.chip_sel_n) mem[word] = bus;
endmodule
`default_nettype wire

// ### nhp_tb.sv
`timescale 1ns/10ps
`default_nettype none
module testbench
  import nhp_pkg::*;
;
  logic core_clk, reset_n, mux_mode, req_valid, req_ready, rsp_valid, dev_reset_n;
  logic dev_data_oe, busy_n, irq_n, dma_n, irq_pending, dma_pending, irq_cmd, dma_cmd;
  logic [DATA_WIDTH-1:0] rsp_data, dev_data_out, bus;
  logic [ADDR_WIDTH-1:0] dev_addr;
  nhp_req_type req;
  nhp_strobe_type strobe;
  int err_count = 0;
  int check_count = 0;
  nhp_host dut (.core_clk(core_clk), .reset_n(reset_n), .mux_mode(mux_mode),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .dev_reset_n(dev_reset_n), .dev_addr(dev_addr),
    .dev_strobe(strobe), .dev_data_out(dev_data_out), .dev_data_oe(dev_data_oe),
    .dev_data_in(bus), .dev_busy_n(busy_n), .dev_irq_n(irq_n),
    .dev_dma_request_n(dma_n), .irq_pending(irq_pending), .dma_pending(dma_pending));
  nhp_dev_model u_dev (.dev_reset_n(dev_reset_n), .dev_addr(dev_addr), .strobe(strobe),
    .host_data(dev_data_out), .host_oe(dev_data_oe), .irq_cmd(irq_cmd), .dma_cmd(dma_cmd),
    .bus(bus), .busy_n(busy_n), .irq_n(irq_n), .dma_request_n(dma_n));
  // ****************
  // Shared tasks
  // ****************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    if (err_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic xfer(input logic wr, input logic [12:0] a, input logic [15:0] d, input int lat);
    int n;
    @(posedge core_clk);
    #5 req = '{write: wr, addr: a, wdata: d};
    req_valid = 1'b1;
    n = 0;
    @(negedge core_clk);
    while (req_ready !== 1'b1 && n < 50) begin
      n++;
      @(negedge core_clk);
    end
    @(posedge core_clk);
    #5 req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    check("latency", 16'(n), 16'(lat));
    if (!wr) check("rdata", rsp_data, d);
    if (!wr) check("read_oe", {15'h0, dev_data_oe}, 16'h0);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic do_reset(input logic mode);
    int n;
    @(posedge core_clk);
    #5 reset_n = 1'b0;
    mux_mode = mode;
    repeat (8) @(posedge core_clk);
    #5 reset_n = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge core_clk);
      if (busy_n === 1'b0) check("ready_busy", {15'h0, req_ready}, 16'h0);
      n++;
    end
    check("ready", {15'h0, req_ready}, 16'h1);
    check("mux_on", {15'h0, u_dev.mux_on}, {15'h0, mode});
  endtask
  task automatic test_std_rw();
    xfer(1'b1, 13'h0000, 16'ha55a, 5);
    xfer(1'b1, 13'h1ffe, 16'h3cc3, 5);
    xfer(1'b0, 13'h0000, 16'ha55a, 4);
    xfer(1'b0, 13'h1ffe, 16'h3cc3, 4);
  endtask
  task automatic test_irq_dma();
    logic [1:0] pat [3] = '{2'b10, 2'b01, 2'b00};
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      #5 {irq_cmd, dma_cmd} = pat[i];
      repeat (3) @(negedge core_clk);
      check("irq", {15'h0, irq_pending}, {15'h0, pat[i][1]});
      check("dma", {15'h0, dma_pending}, {15'h0, pat[i][0]});
    end
  endtask
  task automatic test_mux_rw();
    xfer(1'b0, 13'h1ffe, 16'h3cc3, 6);
    xfer(1'b1, 13'h0002, 16'h0ff0, 7);
    xfer(1'b0, 13'h0000, 16'ha55a, 6);
    xfer(1'b0, 13'h0002, 16'h0ff0, 6);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    #200000;
    err_count++;
    test_done();
  end
  initial begin
    reset_n = 1'b0;
    mux_mode = 1'b0;
    req_valid = 1'b0;
    req = '0;
    irq_cmd = 1'b0;
    dma_cmd = 1'b0;
    do_reset(1'b0);
    test_std_rw();
    test_irq_dma();
    do_reset(1'b1);
    test_mux_rw();
    test_done();
  end
endmodule
`default_nettype wire
